// [udc_cfg.svh]
`ifndef UDC_CFG_SVH
`define UDC_CFG_SVH

// register byte offsets
`define UDC_OFF_CTRL 8'h00
`define UDC_OFF_PERIOD 8'h04
`define UDC_OFF_COMPARE 8'h08
`define UDC_OFF_COUNT 8'h0c
`define UDC_OFF_STATUS 8'h10
`define UDC_OFF_CAPTURE 8'h14

// control field positions
`define UDC_CTRL_SW_EN 0
`define UDC_CTRL_EN_MODE_LO 1
`define UDC_CTRL_EN_MODE_HI 2
`define UDC_CTRL_CLK_MODE_LO 3
`define UDC_CTRL_CLK_MODE_HI 4
`define UDC_CTRL_CMP_MODE_LO 5
`define UDC_CTRL_CMP_MODE_HI 7
`define UDC_CTRL_CAP_MODE_LO 8
`define UDC_CTRL_CAP_MODE_HI 9
`define UDC_CTRL_MASK_LO 10
`define UDC_CTRL_MASK_HI 12

// status field positions
`define UDC_ST_TC 0
`define UDC_ST_CMP 1
`define UDC_ST_NOT_EMPTY 2
`define UDC_ST_OVERFLOW 3
`define UDC_ST_UNDERFLOW 4
`define UDC_ST_TC_EVENT 5
`define UDC_ST_CAP_EVENT 6
`define UDC_ST_FULL 7

// reset values
`define UDC_CTRL_RST 32'h0000_0000
`define UDC_PERIOD_RST 32'h0000_00ff
`define UDC_COMPARE_RST 32'h0000_0080

// capture storage depth
`define UDC_CAP_DEPTH 4

`endif

// [udc_pkg.sv]
package udc_pkg;

    typedef enum logic [1:0] {
        UDC_CLK_UP,
        UDC_CLK_DOWN,
        UDC_CLK_DIR,
        UDC_CLK_DUAL
    } udc_clk_mode_t;

    typedef enum logic [2:0] {
        UDC_CMP_LT,
        UDC_CMP_LE,
        UDC_CMP_EQ,
        UDC_CMP_GT,
        UDC_CMP_GE
    } udc_cmp_mode_t;

    typedef enum logic [1:0] {
        UDC_EN_SW,
        UDC_EN_HW,
        UDC_EN_BOTH
    } udc_en_mode_t;

endpackage

// [udc_counter.sv]
// Functional notes
// [RULE1] single-input modes count one event per rising edge of count_in only
// [RULE2] down counter: zero is terminal, reload period and keep running
// [RULE3] up counter: period is terminal, reload zero afterwards
// [RULE4] count plus direction: direction 1 adds one, 0 subtracts one
// [RULE5] dual mode: pulses sampled on oversample clock, up adds, down subtracts
// [RULE6] dual mode: separate overflow and underflow flags, reload period
// [RULE7] compare result against compare value driven every cycle
// [RULE8] capture rising edge pushes count into four-entry fifo
// [RULE9] effective enable from software bit, hardware input, or both
// [RULE10] hardware enable low holds the count unchanged
// [RULE11] reset input rising reloads like terminal count, high holds it
// [RULE12] start value zero for up mode, period for other modes
// [RULE13] terminal_count_flag low while held in reset
// [RULE14] interrupt enable for any mix of terminal, compare, capture
// [RULE15] enable and direction inputs pass a two-stage synchroniser
// [RULE16] count_in used except in dual mode, oversample clock only there
// [RULE17] capture mode none disables capture entirely
// [RULE18] terminal_count_flag high while count sits at terminal value
// [RULE19] interrupt is the or of all enabled status sources
// [RULE20] compare relations lt, le, eq, gt, ge of count against compare
// [RULE21] full fifo drops captures, read pops oldest, not-empty reported
// [RULE22] edges found against previous cycle sample, one event per edge
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "udc_cfg.svh"

module udc_counter #(
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_in,
    input wire logic count_direction,
    input wire logic increment_pulse,
    input wire logic decrement_pulse,
    input wire logic oversample_clk,
    input wire logic enable_in,
    input wire logic reset_in,
    input wire logic capture_in,
    output logic terminal_count_flag,
    output logic compare_match_out,
    output logic interrupt_out
);
    import udc_pkg::*;

    initial begin
        if (WIDTH != 8 && WIDTH != 16 && WIDTH != 24 && WIDTH != 32) begin
            $error("udc_counter: WIDTH must be 8, 16, 24 or 32");
        end
    end

    localparam int DEPTH = `UDC_CAP_DEPTH;
    localparam logic [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};
    localparam logic [WIDTH-1:0] ZERO = {WIDTH{1'b0}};

    function automatic logic [31:0] ext(input logic [WIDTH-1:0] v);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[WIDTH-1:0] = v;
        return r;
    endfunction

    function automatic logic relate(input udc_cmp_mode_t m,
                                    input logic [WIDTH-1:0] a,
                                    input logic [WIDTH-1:0] b);
        logic r;
        r = 1'b0;
        unique case (m)
            UDC_CMP_LT: r = a < b;
            UDC_CMP_LE: r = a <= b;
            UDC_CMP_EQ: r = a == b;
            UDC_CMP_GT: r = a > b;
            UDC_CMP_GE: r = a >= b;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    logic [31:0] ctrl;
    logic [WIDTH-1:0] period;
    logic [WIDTH-1:0] compare_val;
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic en_s1, en_s2, dir_s1, dir_s2;
    logic count_prev, ovs_prev, inc_prev, dec_prev, cap_prev, tc_prev;
    logic overflow, underflow, tc_event, cap_event;
    logic next_overflow, next_underflow;
    logic [WIDTH-1:0] fifo_mem [DEPTH];
    logic [1:0] wr_ptr, rd_ptr;
    logic [2:0] fill;

    // control field decode
    wire udc_clk_mode_t clk_mode =
        udc_clk_mode_t'(ctrl[`UDC_CTRL_CLK_MODE_HI:`UDC_CTRL_CLK_MODE_LO]);
    wire udc_cmp_mode_t cmp_mode =
        udc_cmp_mode_t'(ctrl[`UDC_CTRL_CMP_MODE_HI:`UDC_CTRL_CMP_MODE_LO]);
    wire udc_en_mode_t en_mode =
        udc_en_mode_t'(ctrl[`UDC_CTRL_EN_MODE_HI:`UDC_CTRL_EN_MODE_LO]);
    wire logic sw_en = ctrl[`UDC_CTRL_SW_EN];
    wire logic cap_on =
        ctrl[`UDC_CTRL_CAP_MODE_HI:`UDC_CTRL_CAP_MODE_LO] != 2'b00; // [RULE17]
    wire logic [2:0] irq_mask = ctrl[`UDC_CTRL_MASK_HI:`UDC_CTRL_MASK_LO];

    // apb decode
    wire logic setup = psel && !penable;
    wire logic access = psel && penable && pready;
    wire logic wr = access && pwrite;
    wire logic rd = access && !pwrite;
    wire logic hit_ctrl = paddr == `UDC_OFF_CTRL;
    wire logic hit_period = paddr == `UDC_OFF_PERIOD;
    wire logic hit_cmp = paddr == `UDC_OFF_COMPARE;
    wire logic hit_count = paddr == `UDC_OFF_COUNT;
    wire logic hit_status = paddr == `UDC_OFF_STATUS;
    wire logic hit_cap = paddr == `UDC_OFF_CAPTURE;
    wire logic mapped = hit_ctrl || hit_period || hit_cmp || hit_count ||
                        hit_status || hit_cap;
    wire logic status_rd = rd && hit_status;

    // effective enable
    wire logic eff_en = (en_mode == UDC_EN_SW) ? sw_en :
                        (en_mode == UDC_EN_HW) ? en_s2 :
                        (en_mode == UDC_EN_BOTH) ? (sw_en && en_s2) :
                        1'b0; // [RULE9] [RULE10]

    // edge detection against the previous sample: each cycle, or each oversample edge for the pulses
    wire logic dual = clk_mode == UDC_CLK_DUAL;
    wire logic count_rise = !dual && count_in && !count_prev; // [RULE1] [RULE16] [RULE22]
    wire logic ovs_rise = dual && oversample_clk && !ovs_prev; // [RULE16]
    // pulses are only looked at on an oversample edge, so a pulse
    // shorter than the oversample period may be missed
    wire logic inc_rise = ovs_rise && increment_pulse && !inc_prev; // [RULE5]
    wire logic dec_rise = ovs_rise && decrement_pulse && !dec_prev; // [RULE5]
    wire logic cap_rise = cap_on && capture_in && !cap_prev; // [RULE22]

    wire logic step_up = eff_en && (dual ? (inc_rise && !dec_rise) :
        count_rise && (clk_mode == UDC_CLK_UP ||
                       (clk_mode == UDC_CLK_DIR && dir_s2))); // [RULE4] [RULE5]
    wire logic step_down = eff_en && (dual ? (dec_rise && !inc_rise) :
        count_rise && (clk_mode == UDC_CLK_DOWN ||
                       (clk_mode == UDC_CLK_DIR && !dir_s2))); // [RULE4] [RULE5]

    wire logic [WIDTH-1:0] start_val =
        (clk_mode == UDC_CLK_UP) ? ZERO : period; // [RULE12]
    wire logic [WIDTH-1:0] term_val =
        (clk_mode == UDC_CLK_UP) ? period : ZERO;
    wire logic up_down = clk_mode == UDC_CLK_DIR || dual;
    // the two-way modes reload period at both ends of the range
    wire logic at_term = up_down ? (count == ALL_ONES || count == ZERO) :
                         (count == term_val); // [RULE18]

    always_comb begin
        next_count = count;
        next_overflow = overflow && !status_rd;
        next_underflow = underflow && !status_rd;
        if (reset_in) begin
            next_count = start_val; // [RULE11] [RULE12]
        end else if (step_up) begin
            if (up_down && count == ALL_ONES) begin
                next_count = period; // [RULE6]
                next_overflow = 1'b1; // [RULE6]
            end else if (!up_down && count == period) begin
                next_count = ZERO; // [RULE3]
            end else begin
                next_count = count + 1'b1; // [RULE3] [RULE4]
            end
        end else if (step_down) begin
            if (count == ZERO) begin
                next_count = period; // [RULE2] [RULE6]
                next_underflow = up_down || next_underflow; // [RULE6]
            end else begin
                next_count = count - 1'b1; // [RULE2] [RULE4]
            end
        end
    end

    wire logic tc_now = at_term && !reset_in;
    wire logic tc_rise = tc_now && !tc_prev;
    wire logic cmp_now = relate(cmp_mode, count, compare_val); // [RULE20]

    // capture fifo
    wire logic fifo_full = fill == 3'(DEPTH);
    wire logic fifo_empty = fill == 3'd0;
    wire logic push = cap_rise && !fifo_full; // [RULE8] [RULE21]
    wire logic pop = rd && hit_cap && !fifo_empty; // [RULE21]
    wire logic [2:0] next_fill = fill + 3'(push) - 3'(pop);

    wire logic [31:0] status_word = ext(ZERO) |
        (32'(terminal_count_flag) << `UDC_ST_TC) |
        (32'(compare_match_out) << `UDC_ST_CMP) |
        (32'(!fifo_empty) << `UDC_ST_NOT_EMPTY) |
        (32'(overflow) << `UDC_ST_OVERFLOW) |
        (32'(underflow) << `UDC_ST_UNDERFLOW) |
        (32'(tc_event) << `UDC_ST_TC_EVENT) |
        (32'(cap_event) << `UDC_ST_CAP_EVENT) |
        (32'(fifo_full) << `UDC_ST_FULL); // [RULE21]

    wire logic [31:0] read_mux =
        hit_ctrl ? ctrl :
        hit_period ? ext(period) :
        hit_cmp ? ext(compare_val) :
        hit_count ? ext(count) :
        hit_status ? status_word :
        (hit_cap && !fifo_empty) ? ext(fifo_mem[rd_ptr]) :
        32'h0000_0000;

    // interrupt sources: terminal event, compare level, capture event
    wire logic next_irq = (irq_mask[0] && tc_event) ||
                          (irq_mask[1] && compare_match_out) ||
                          (irq_mask[2] && cap_event); // [RULE14] [RULE19]

    // pready is registered: one wait-free access phase after each setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            // write accesses return zero so stale data never shows
            prdata <= (setup && !pwrite) ? read_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `UDC_CTRL_RST;
            period <= WIDTH'(`UDC_PERIOD_RST);
            compare_val <= WIDTH'(`UDC_COMPARE_RST);
        end else if (wr) begin
            if (hit_ctrl) begin
                ctrl <= pwdata;
            end
            if (hit_period) begin
                period <= pwdata[WIDTH-1:0];
            end
            if (hit_cmp) begin
                compare_val <= pwdata[WIDTH-1:0];
            end
        end
    end

    // only the second stage is read anywhere
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_s1 <= 1'b0;
            en_s2 <= 1'b0;
            dir_s1 <= 1'b0;
            dir_s2 <= 1'b0;
        end else begin
            en_s1 <= enable_in; // [RULE15]
            en_s2 <= en_s1; // [RULE15]
            dir_s1 <= count_direction; // [RULE15]
            dir_s2 <= dir_s1; // [RULE15]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_prev <= 1'b0;
            ovs_prev <= 1'b0;
            inc_prev <= 1'b0;
            dec_prev <= 1'b0;
            cap_prev <= 1'b0;
            tc_prev <= 1'b0;
        end else begin
            count_prev <= count_in;
            ovs_prev <= oversample_clk;
            cap_prev <= capture_in;
            tc_prev <= tc_now;
            if (ovs_rise) begin
                inc_prev <= increment_pulse;
                dec_prev <= decrement_pulse;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= ZERO;
            overflow <= 1'b0;
            underflow <= 1'b0;
        end else begin
            count <= next_count;
            overflow <= next_overflow;
            underflow <= next_underflow;
        end
    end

    // sticky events: a new event in the clearing read cycle survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc_event <= 1'b0;
            cap_event <= 1'b0;
        end else begin
            tc_event <= tc_rise || (tc_event && !status_rd);
            cap_event <= cap_rise || (cap_event && !status_rd);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            terminal_count_flag <= 1'b0;
            compare_match_out <= 1'b0;
            interrupt_out <= 1'b0;
        end else begin
            terminal_count_flag <= tc_now; // [RULE13] [RULE18]
            compare_match_out <= cmp_now; // [RULE7]
            interrupt_out <= next_irq; // [RULE19]
        end
    end

    always_ff @(posedge pclk) begin
        if (push) begin
            fifo_mem[wr_ptr] <= count; // [RULE8]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= 2'd0;
            rd_ptr <= 2'd0;
            fill <= 3'd0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 2'd1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 2'd1; // [RULE21]
            end
            fill <= next_fill;
        end
    end

endmodule
`default_nettype wire

// [udc_counter_props.sv]
`timescale 1ns/1ps
`default_nettype none
module udc_counter_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic count_in,
    input wire logic increment_pulse,
    input wire logic decrement_pulse,
    input wire logic reset_in,
    input wire logic capture_in,
    input wire logic terminal_count_flag,
    input wire logic compare_match_out
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    // three idle cycles cover the two-cycle lag through the count and output registers
    sequence s_quiet;
        !reset_in && !psel && !count_in && !capture_in &&
            !increment_pulse && !decrement_pulse;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("prdata not zero outside read");
    a_map_error: assert property ((s_setup and (paddr[1:0] == 2'b00))
        |=> pslverr == ($past(paddr) > 8'h14))
        else $error("pslverr wrong for address");
    a_tc_in_reset: assert property (reset_in |=> !terminal_count_flag)
        else $error("terminal count high in reset");
    a_tc_steady: assert property ( // idle hold
        s_quiet [*3] |-> $stable(terminal_count_flag))
        else $error("terminal count moved without event");
    a_cmp_steady: assert property ( // idle hold
        s_quiet [*3] |-> $stable(compare_match_out))
        else $error("compare moved without cause");
endmodule
bind udc_counter udc_counter_props u_props (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .count_in,
    .increment_pulse, .decrement_pulse, .reset_in, .capture_in,
    .terminal_count_flag, .compare_match_out);
`default_nettype wire

// [udc_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module udc_partner (
    input wire logic pclk,
    input wire logic start,
    input wire logic [1:0] sel,
    input wire logic [3:0] n,
    output logic busy,
    output logic count_in,
    output logic capture_in,
    output logic increment_pulse,
    output logic decrement_pulse,
    output logic oversample_clk
);
    logic [3:0] lines;
    logic [1:0] div = 2'h0;
    assign count_in = lines[0];
    assign capture_in = lines[1];
    assign increment_pulse = lines[2];
    assign decrement_pulse = lines[3];
    // free-running oversample clock at a quarter of pclk
    assign oversample_clk = div[1];
    always @(posedge pclk) div <= div + 2'h1;
    // pulses of 8 cycles so at least two oversample points see each level
    initial begin
        lines = 4'h0;
        busy = 1'b0;
        forever begin
            @(posedge pclk);
            if (start) begin
                busy <= 1'b1;
                repeat (n) begin
                    lines[sel] <= 1'b1;
                    repeat (8) @(posedge pclk);
                    lines[sel] <= 1'b0;
                    repeat (8) @(posedge pclk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [tb_updown_event_counter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "udc_cfg.svh"
module tb_updown_event_counter;
    import udc_pkg::*;
    typedef struct packed {
        logic [1:0] clk; logic dir; logic [2:0] cmp; logic [7:0] per;
        logic [7:0] cv; logic [3:0] n; logic [7:0] exp;
    } udc_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, busy;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic count_in, count_direction, increment_pulse, decrement_pulse;
    logic oversample_clk, enable_in, reset_in, capture_in, start;
    logic terminal_count_flag, compare_match_out, interrupt_out;
    logic [1:0] sel;
    logic [3:0] n;
    udc_row_t r;
    int n_errors = 0;
    int num_checks = 0;
    // clk dir cmp period compare pulses count
    udc_row_t rows [7] = '{'{2'h0,1'h0,3'h0,8'h05,8'h03,4'h7,8'h01},
        '{2'h1,1'h0,3'h1,8'h05,8'h04,4'h7,8'h04},
        '{2'h2,1'h1,3'h2,8'h80,8'h83,4'h3,8'h83},
        '{2'h2,1'h0,3'h3,8'h80,8'h7c,4'h3,8'h7d},
        '{2'h0,1'h0,3'h4,8'h10,8'h05,4'h4,8'h04},
        '{2'h1,1'h0,3'h3,8'h03,8'h01,4'h4,8'h03},
        '{2'h0,1'h0,3'h0,8'h10,8'h04,4'h4,8'h04}};
    udc_counter #(.WIDTH(8)) u_dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .count_in,
        .count_direction, .increment_pulse, .decrement_pulse,
        .oversample_clk, .enable_in, .reset_in, .capture_in,
        .terminal_count_flag, .compare_match_out, .interrupt_out);
    udc_partner u_partner (.pclk, .start, .sel, .n, .busy, .count_in,
        .capture_in, .increment_pulse, .decrement_pulse, .oversample_clk);
    function automatic logic rel(logic [2:0] m, logic [7:0] a, logic [7:0] b);
        case (m)
            3'h0: return a < b;
            3'h1: return a <= b;
            3'h2: return a == b;
            3'h3: return a > b;
            3'h4: return a >= b;
            default: return 1'b0;
        endcase
    endfunction
    function automatic logic [31:0] cw(logic [1:0] c, logic [2:0] m,
        logic [1:0] e, logic cap, logic [2:0] k, logic sw);
        return {19'h0, k, 1'b0, cap, m, c, e, sw};
    endfunction
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(logic [7:0] a, logic [31:0] exp, string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    task automatic drive(logic [1:0] s, logic [3:0] k);
        @(posedge pclk);
        sel <= s;
        n <= k;
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        do @(posedge pclk); while (busy !== 1'b0);
        repeat (4) @(posedge pclk);
    endtask
    task automatic arm(logic [31:0] c, logic [7:0] p, logic [7:0] v);
        apb(1'b1, `UDC_OFF_PERIOD, {24'h0, p});
        apb(1'b1, `UDC_OFF_COMPARE, {24'h0, v});
        apb(1'b1, `UDC_OFF_CTRL, c);
        @(posedge pclk);
        reset_in <= 1'b1;
        repeat (2) @(posedge pclk);
        reset_in <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #200000;
        n_errors++;
        complete_run();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {count_direction, enable_in, reset_in, start, sel, n} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`UDC_OFF_CTRL, `UDC_CTRL_RST, "ctrl");
        rchk(`UDC_OFF_PERIOD, `UDC_PERIOD_RST, "period");
        rchk(`UDC_OFF_COMPARE, `UDC_COMPARE_RST, "compare");
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", {30'h0, er, rd[0]}, 32'h2);
        foreach (rows[i]) begin
            r = rows[i];
            count_direction <= r.dir;
            arm(cw(r.clk, r.cmp, UDC_EN_SW, 1'b0, 3'h0, 1'b1), r.per, r.cv);
            drive(2'h0, r.n);
            rchk(`UDC_OFF_COUNT, {24'h0, r.exp}, "count");
            chk("cmp", {31'h0, compare_match_out}, {31'h0, rel(r.cmp, r.exp, r.cv)});
        end
        arm(cw(UDC_CLK_UP, 3'h0, UDC_EN_HW, 1'b0, 3'h0, 1'b0), 8'h20, 8'h0);
        drive(2'h0, 4'h2);
        rchk(`UDC_OFF_COUNT, 32'h0, "hw off");
        enable_in <= 1'b1;
        drive(2'h0, 4'h3);
        rchk(`UDC_OFF_COUNT, 32'h3, "hw on");
        apb(1'b1, `UDC_OFF_CTRL, cw(UDC_CLK_UP, 3'h0, UDC_EN_BOTH, 1'b0, 3'h0, 1'b0));
        drive(2'h0, 4'h2);
        rchk(`UDC_OFF_COUNT, 32'h3, "both");
        arm(cw(UDC_CLK_UP, 3'h0, UDC_EN_SW, 1'b0, 3'h0, 1'b1), 8'h20, 8'h0);
        drive(2'h1, 4'h1);
        rchk(`UDC_OFF_CAPTURE, 32'h0, "cap none");
        apb(1'b1, `UDC_OFF_CTRL, cw(UDC_CLK_UP, 3'h0, UDC_EN_SW, 1'b1, 3'h4, 1'b1));
        for (int k = 0; k < 5; k++) begin
            drive(2'h0, 4'h1);
            drive(2'h1, 4'h1);
        end
        chk("irq cap", {31'h0, interrupt_out}, 32'h1);
        apb(1'b0, `UDC_OFF_STATUS, 32'h0);
        chk("full", rd & 32'h84, 32'h84);
        repeat (3) @(posedge pclk);
        chk("irq clear", {31'h0, interrupt_out}, 32'h0);
        for (int k = 1; k < 5; k++) begin
            rchk(`UDC_OFF_CAPTURE, k, "cap entry");
        end
        rchk(`UDC_OFF_CAPTURE, 32'h0, "cap empty");
        arm(cw(UDC_CLK_UP, 3'h0, UDC_EN_SW, 1'b0, 3'h1, 1'b1), 8'h2, 8'h0);
        drive(2'h0, 4'h2);
        chk("tc", {31'h0, terminal_count_flag}, 32'h1);
        apb(1'b1, `UDC_OFF_CTRL, cw(UDC_CLK_UP, 3'h0, UDC_EN_SW, 1'b0, 3'h1, 1'b0));
        drive(2'h0, 4'h1);
        chk("tc held", {31'h0, terminal_count_flag}, 32'h1);
        chk("irq tc", {31'h0, interrupt_out}, 32'h1);
        reset_in <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("tc reset", {31'h0, terminal_count_flag}, 32'h0);
        reset_in <= 1'b0;
        arm(cw(UDC_CLK_DUAL, 3'h0, UDC_EN_SW, 1'b0, 3'h0, 1'b1), 8'hfe, 8'h0);
        drive(2'h2, 4'h3);
        drive(2'h3, 4'h1);
        drive(2'h0, 4'h2);
        rchk(`UDC_OFF_COUNT, 32'hfe, "dual");
        apb(1'b0, `UDC_OFF_STATUS, 32'h0);
        chk("overflow", rd & 32'h18, 32'h08);
        arm(cw(UDC_CLK_DUAL, 3'h0, UDC_EN_SW, 1'b0, 3'h0, 1'b1), 8'h01, 8'h0);
        drive(2'h3, 4'h2);
        rchk(`UDC_OFF_COUNT, 32'h01, "dual down");
        apb(1'b0, `UDC_OFF_STATUS, 32'h0);
        chk("underflow", rd & 32'h18, 32'h10);
        apb(1'b1, `UDC_OFF_CTRL,
            cw(UDC_CLK_DUAL, 3'h4, UDC_EN_SW, 1'b0, 3'h2, 1'b1));
        repeat (3) @(posedge pclk);
        chk("irq cmp", {31'h0, interrupt_out}, 32'h1);
        complete_run();
    end
endmodule
`default_nettype wire
